// [design/pin_mux_defines.vh]
// constants for the shared boot-rom / video-module pin group multiplexer
// assumes a single core clock and a synchronous active-low reset
//
// Overview of operation
// RULE1: vertical sync polarity is programmable
// RULE2: vertical sync floats while sync enable low
// RULE3: 64K bios drives address bit 15
// RULE4: strapped low bit15 pin: 32K, serial data
// RULE5: rom mode drives address bits 14..7
// RULE6: video module mode: upper pins are video
// RULE7: no bit1 strap: upper pins carry pixels
// RULE8: test mode: upper pins carry tests 24-31
// RULE9: pin 6: data/read strobe, or test 8
// RULE10: pin 5: direction/write strobe, or test 9
// RULE11: pin 4: acknowledge/ready input, or test 10
// RULE12: low pins: host address, or tests 11-14
// RULE13: select pin: chip select, or test 15
// RULE14: data pins: rom, host data, tests 7-0
// RULE15: rom select enables rom onto data
// RULE16: rom select strapped low disables rom
// RULE17: serial port two uses clock pin, bit15
// RULE18: video enable gates pixels or flags valid
// RULE19: sync enable gates syncs or is gpio
// RULE20: straps sampled at reset end, held
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// ******
// pin group widths
// ******
`define UPPER_W      8
`define LOW_W        4
`define DATA_W       8
`define TEST_W       32

// ******
// operating modes
// ******
`define MODE_W       2
`define MODE_ROM     2'h0
`define MODE_VIDEO   2'h1
`define MODE_TEST    2'h2

// ******
// test output positions
// ******
`define T_UPPER_LSB  24
`define T_PIN6       8
`define T_PIN5       9
`define T_PIN4       10
`define T_LOW_LSB    11
`define T_SEL        15
`define T_DATA_LSB   0

// ******
// strap reset values
// ******
`define STRAP_RST    1'h0

`endif

// [design/rom_video_port_pin_mux.v]
// shared boot-rom pin group multiplexer: rom bus, video-module port,
// feature connector pixel bus, test outputs and second serial port
// assumes all core-side inputs are on ref_clk; pins are resynchronised
`timescale 1ns/10ps
`include "pin_mux_defines.vh"

module rom_video_port_pin_mux
(
    input  wire                   ref_clk,
    input  wire                   rst_b,
    // configuration
    input  wire [`MODE_W-1:0]     mode_sel,
    input  wire                   video_sub_mode,
    input  wire                   vsync_polarity,
    // core side rom access
    input  wire                   rom_read_req,
    input  wire [15:0]            rom_addr,
    output reg  [`DATA_W-1:0]     rom_rdata_r,
    output reg                    rom_rdata_valid_r,
    // core side video-module host access
    input  wire [`LOW_W-1:0]      host_addr_bus,
    input  wire [`DATA_W-1:0]     host_wdata,
    input  wire                   host_write,
    input  wire                   host_cycle,
    input  wire                   periph_select,
    output reg  [`DATA_W-1:0]     host_rdata_r,
    output reg                    transfer_ack_r,
    output reg  [`UPPER_W-1:0]    video_in_bus_r,
    output reg                    video_valid_r,
    // feature connector
    input  wire [`UPPER_W-1:0]    pixel_data,
    input  wire                   vsync_core,
    // test outputs
    input  wire [`TEST_W-1:0]     test_out,
    // second serial port, open drain
    input  wire                   serial2_clock_drive_low,
    input  wire                   serial2_data_drive_low,
    output reg                    serial2_clock_r,
    output reg                    serial2_data_r,
    // general purpose on the sync enable pin in video mode
    input  wire                   gpio_out,
    input  wire                   gpio_oe,
    output reg                    gpio_in_r,
    // strap status
    output wire                   bios_32k,
    output wire                   pixel_bus_en,
    output wire                   rom_absent,
    // pins
    input  wire                   vsync_pin_in,
    output reg                    vsync_pin_out,
    output reg                    vsync_pin_oe,
    input  wire                   rom_addr_bit15_pin_in,
    output reg                    rom_addr_bit15_pin_out,
    output reg                    rom_addr_bit15_pin_oe,
    input  wire [`UPPER_W-1:0]    rom_addr_upper_pins_in,
    output reg  [`UPPER_W-1:0]    rom_addr_upper_pins_out,
    output reg                    rom_addr_upper_pins_oe,
    input  wire                   rom_addr_bit6_pin_in,
    output reg                    rom_addr_bit6_pin_out,
    output reg                    rom_addr_bit6_pin_oe,
    input  wire                   rom_addr_bit5_pin_in,
    output reg                    rom_addr_bit5_pin_out,
    output reg                    rom_addr_bit5_pin_oe,
    input  wire                   rom_addr_bit4_pin_in,
    output reg                    rom_addr_bit4_pin_out,
    output reg                    rom_addr_bit4_pin_oe,
    input  wire [`LOW_W-1:0]      rom_addr_low_pins_in,
    output reg  [`LOW_W-1:0]      rom_addr_low_pins_out,
    output reg                    rom_addr_low_pins_oe,
    input  wire                   periph_select_n_in,
    output reg                    periph_select_n_out,
    output reg                    periph_select_n_oe,
    input  wire [`DATA_W-1:0]     rom_data_pins_in,
    output reg  [`DATA_W-1:0]     rom_data_pins_out,
    output reg                    rom_data_pins_oe,
    input  wire                   boot_rom_select_n_in,
    output reg                    boot_rom_select_n_out,
    output reg                    boot_rom_select_n_oe,
    input  wire                   serial2_clock_in,
    output reg                    serial2_clock_out,
    output reg                    serial2_clock_oe,
    input  wire                   sync_buffer_enable_n_in,
    output reg                    sync_buffer_enable_n_out,
    output reg                    sync_buffer_enable_n_oe,
    input  wire                   video_buffer_enable_n_in
);

    // ******
    // pin input synchronisers
    // ******
    localparam SYNC_W = `UPPER_W + `DATA_W + 7;

    wire [SYNC_W-1:0] pins_raw;
    reg  [SYNC_W-1:0] pins_s1_r;
    reg  [SYNC_W-1:0] pins_s2_r;

    assign pins_raw = {rom_addr_upper_pins_in, rom_data_pins_in,
                       rom_addr_bit4_pin_in, rom_addr_bit15_pin_in,
                       serial2_clock_in, sync_buffer_enable_n_in,
                       video_buffer_enable_n_in, vsync_pin_in,
                       rom_addr_bit6_pin_in};

    always @(posedge ref_clk)
    begin
        pins_s1_r <= pins_raw;
        pins_s2_r <= pins_s1_r;
    end

    wire [`UPPER_W-1:0] upper_s  = pins_s2_r[SYNC_W-1 -: `UPPER_W];
    wire [`DATA_W-1:0]  data_s   = pins_s2_r[6+`DATA_W -: `DATA_W];
    wire                ack_s    = pins_s2_r[6];
    wire                sda_s    = pins_s2_r[5];
    wire                scl_s    = pins_s2_r[4];
    wire                sync_en_s = pins_s2_r[3];
    wire                vid_en_s = pins_s2_r[2];

    // ******
    // strap capture
    // ******
    wire straps_valid;

    strap_latch u_strap
    (
        .ref_clk        (ref_clk),
        .rst_b          (rst_b),
        .bit15_pin_in   (rom_addr_bit15_pin_in),
        .bit1_pin_in    (rom_addr_low_pins_in[1]),
        .rom_sel_pin_in (boot_rom_select_n_in),
        .bios_32k_r     (bios_32k),
        .pixel_bus_en_r (pixel_bus_en),
        .rom_absent_r   (rom_absent),
        .straps_valid_r (straps_valid)
    );

    // ******
    // mode decode
    // ******
    wire mode_video = (mode_sel == `MODE_VIDEO);
    wire mode_test  = (mode_sel == `MODE_TEST);
    wire mode_rom   = ~mode_video & ~mode_test;
    // rom cycles are held off until straps are known, so a strapped-low
    // select never sees a stray access
    wire rom_go     = mode_rom & rom_read_req & ~rom_absent & straps_valid;   // [RULE16]

    // ******
    // pin drive
    // ******
    always @*
    begin
        // vertical sync
        vsync_pin_out = vsync_core ^ vsync_polarity; // [RULE1]
        vsync_pin_oe  = ~mode_video & sync_en_s; // [RULE2] [RULE19]

        // address bit 15: address for 64K, else serial data only
        if (mode_rom && !bios_32k && rom_go)
        begin
            rom_addr_bit15_pin_out = rom_addr[15]; // [RULE3]
            rom_addr_bit15_pin_oe  = 1'h1;
        end
        else
        begin
            rom_addr_bit15_pin_out = 1'h0; // [RULE4] [RULE17]
            rom_addr_bit15_pin_oe  = serial2_data_drive_low;
        end

        // upper group
        if (mode_test)
        begin
            rom_addr_upper_pins_out = test_out[`T_UPPER_LSB +: `UPPER_W]; // [RULE8]
            rom_addr_upper_pins_oe  = 1'h1;
        end
        else if (mode_video)
        begin
            rom_addr_upper_pins_out = {`UPPER_W{1'h0}}; // [RULE6]
            rom_addr_upper_pins_oe  = 1'h0;
        end
        else if (rom_go)
        begin
            rom_addr_upper_pins_out = rom_addr[14:7]; // [RULE5]
            rom_addr_upper_pins_oe  = 1'h1;
        end
        else
        begin
            // pixel bus buffers follow the active-low video enable
            rom_addr_upper_pins_out = pixel_data; // [RULE7]
            rom_addr_upper_pins_oe  = pixel_bus_en & ~vid_en_s; // [RULE18]
        end

        // strobes, address low, chip select
        if (mode_test)
        begin
            rom_addr_bit6_pin_out = test_out[`T_PIN6];                 // [RULE9]
            rom_addr_bit5_pin_out = test_out[`T_PIN5];                 // [RULE10]
            rom_addr_bit4_pin_out = test_out[`T_PIN4];                 // [RULE11]
            rom_addr_low_pins_out = test_out[`T_LOW_LSB +: `LOW_W];    // [RULE12]
            periph_select_n_out   = test_out[`T_SEL];                  // [RULE13]
            rom_addr_bit4_pin_oe  = 1'h1;
        end
        else if (mode_video)
        begin
            // sub-mode 0: data strobe + direction; 1: read + write strobes
            rom_addr_bit6_pin_out = video_sub_mode ?
                                    ~(host_cycle & ~host_write) : ~host_cycle;   // [RULE9]
            rom_addr_bit5_pin_out = video_sub_mode ?
                                    ~(host_cycle & host_write) : ~host_write;    // [RULE10]
            rom_addr_bit4_pin_out = 1'h0;
            rom_addr_low_pins_out = host_addr_bus;                     // [RULE12]
            periph_select_n_out   = ~periph_select;                    // [RULE13]
            rom_addr_bit4_pin_oe  = 1'h0;                              // [RULE11]
        end
        else
        begin
            rom_addr_bit6_pin_out = rom_addr[6];
            rom_addr_bit5_pin_out = rom_addr[5];
            rom_addr_bit4_pin_out = rom_addr[4];
            rom_addr_low_pins_out = rom_addr[3:0];
            periph_select_n_out   = 1'h1;
            rom_addr_bit4_pin_oe  = rom_go;
        end
        rom_addr_bit6_pin_oe  = mode_test | mode_video | rom_go;
        rom_addr_bit5_pin_oe  = mode_test | mode_video | rom_go;
        rom_addr_low_pins_oe  = mode_test | mode_video | rom_go;
        periph_select_n_oe    = mode_test | mode_video;

        // data bus
        if (mode_test)
        begin
            rom_data_pins_out = test_out[`T_DATA_LSB +: `DATA_W]; // [RULE14]
            rom_data_pins_oe  = 1'h1;
        end
        else if (mode_video)
        begin
            rom_data_pins_out = host_wdata; // [RULE14]
            rom_data_pins_oe  = host_cycle & host_write;
        end
        else
        begin
            rom_data_pins_out = {`DATA_W{1'h0}}; // [RULE14]
            rom_data_pins_oe  = 1'h0;
        end

        // rom select: the pin is released until straps are caught
        boot_rom_select_n_out = ~rom_go; // [RULE15]
        boot_rom_select_n_oe  = straps_valid & ~rom_absent; // [RULE16]

        // open-drain serial clock
        serial2_clock_out = 1'h0; // [RULE17]
        serial2_clock_oe  = serial2_clock_drive_low;

        // sync enable pin is an input outside video mode
        sync_buffer_enable_n_out = gpio_out; // [RULE19]
        sync_buffer_enable_n_oe  = mode_video & gpio_oe;
    end

    // ******
    // captured inputs
    // ******
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rom_rdata_r       <= {`DATA_W{1'h0}};
            rom_rdata_valid_r <= 1'h0;
            host_rdata_r      <= {`DATA_W{1'h0}};
            transfer_ack_r    <= 1'h0;
            video_in_bus_r    <= {`UPPER_W{1'h0}};
            video_valid_r     <= 1'h0;
            serial2_clock_r   <= 1'h1;
            serial2_data_r    <= 1'h1;
            gpio_in_r         <= 1'h0;
        end
        else
        begin
            rom_rdata_valid_r <= rom_go; // [RULE15]
            if (rom_go)
                rom_rdata_r <= data_s;
            if (mode_video)
            begin
                host_rdata_r   <= data_s; // [RULE14]
                transfer_ack_r <= video_sub_mode ? ack_s : ~ack_s; // [RULE11]
                video_in_bus_r <= upper_s; // [RULE6]
                video_valid_r  <= vid_en_s; // [RULE18]
                gpio_in_r      <= sync_en_s; // [RULE19]
            end
            else
            begin
                transfer_ack_r <= 1'h0;
                video_valid_r  <= 1'h0;
            end
            serial2_clock_r <= scl_s; // [RULE17]
            serial2_data_r  <= sda_s;
        end
    end

endmodule

// [design/strap_latch.v]
// strap capture: double-synchronises three strap pins and latches them
// on the first clock after reset is released, holding until next reset
`timescale 1ns/10ps
`include "pin_mux_defines.vh"

module strap_latch
(
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       bit15_pin_in,
    input  wire       bit1_pin_in,
    input  wire       rom_sel_pin_in,
    output reg        bios_32k_r,
    output reg        pixel_bus_en_r,
    output reg        rom_absent_r,
    output reg        straps_valid_r
);

    reg  [2:0]        sync1_r;
    reg  [2:0]        sync2_r;

    always @(posedge ref_clk)
    begin
        sync1_r <= {bit15_pin_in, bit1_pin_in, rom_sel_pin_in};
        sync2_r <= sync1_r;
    end

    // latch once at the first edge after release, then freeze
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            straps_valid_r <= `STRAP_RST;
            bios_32k_r     <= `STRAP_RST;
            pixel_bus_en_r <= `STRAP_RST;
            rom_absent_r   <= `STRAP_RST;
        end
        else if (!straps_valid_r)
        begin
            straps_valid_r <= 1'h1;                 // [RULE20]
            bios_32k_r     <= ~sync2_r[2];          // [RULE4]
            pixel_bus_en_r <= sync2_r[1];           // [RULE7]
            rom_absent_r   <= ~sync2_r[0];          // [RULE16]
        end
    end

endmodule

// [testbench/boot_rom_model.sv]
// boot rom and strap resistors on the shared pin group
// assumes the rom decodes only the upper address pins for its data
`timescale 1ns/10ps

module boot_rom_model
(
    input  logic       ref_clk,
    input  logic       rst_b,
    input  logic       strap_32k,
    input  logic       strap_absent,
    input  logic [7:0] rom_addr_upper_pins_out,
    input  logic       rom_addr_bit15_pin_out,
    input  logic       rom_addr_bit15_pin_oe,
    input  logic [7:0] rom_data_pins_out,
    input  logic       rom_data_pins_oe,
    input  logic       boot_rom_select_n_out,
    input  logic       boot_rom_select_n_oe,
    output logic [7:0] rom_data_pins_in,
    output logic       boot_rom_select_n_in,
    output logic       rom_addr_bit15_pin_in
);
    logic [7:0] last_r = 8'h00;

    // strap shows in reset; the serial pull-up wins once running
    assign rom_addr_bit15_pin_in = rom_addr_bit15_pin_oe ? rom_addr_bit15_pin_out :
        !strap_32k || rst_b;
    assign boot_rom_select_n_in = boot_rom_select_n_oe ? boot_rom_select_n_out : !strap_absent;
    // released bus toggles, so no stale byte passes
    assign rom_data_pins_in = rom_data_pins_oe ? rom_data_pins_out :
        (!boot_rom_select_n_in ? rom_addr_upper_pins_out ^ 8'hA5 : ~last_r);

    always @(posedge ref_clk)
        last_r <= rom_data_pins_in;
endmodule

// [testbench/pin_mux_asserts.sv]
// checker for the shared rom / video-module pin group multiplexer
// sees only the top module ports; bound to every instance at the foot
`timescale 1ns/10ps
`include "pin_mux_defines.vh"

module pin_mux_asserts
(
    input logic        ref_clk,
    input logic        rst_b,
    input logic [1:0]  mode_sel,
    input logic        video_sub_mode,
    input logic        vsync_polarity,
    input logic        vsync_core,
    input logic [15:0] rom_addr,
    input logic [3:0]  host_addr_bus,
    input logic        host_write,
    input logic        host_cycle,
    input logic [31:0] test_out,
    input logic        bios_32k,
    input logic        pixel_bus_en,
    input logic        rom_absent,
    input logic        sync_buffer_enable_n_in,
    input logic        vsync_pin_out,
    input logic        vsync_pin_oe,
    input logic        rom_addr_bit15_pin_out,
    input logic        rom_addr_bit15_pin_oe,
    input logic [7:0]  rom_addr_upper_pins_out,
    input logic        rom_addr_upper_pins_oe,
    input logic        rom_addr_bit6_pin_out,
    input logic        rom_addr_bit5_pin_out,
    input logic [3:0]  rom_addr_low_pins_out,
    input logic [7:0]  rom_data_pins_out,
    input logic        boot_rom_select_n_out,
    input logic        boot_rom_select_n_oe
);
    // ******
    // properties
    // ******
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    vsync_pol_a: assert property (vsync_pin_oe
        |-> vsync_pin_out == (vsync_core ^ vsync_polarity)) else $error("vsync level wrong");
    vsync_float_a: assert property ((!sync_buffer_enable_n_in) [*3] |-> !vsync_pin_oe)
        else $error("vsync driven while sync enable low");
    bit15_a: assert property (rom_addr_bit15_pin_oe && rom_addr_bit15_pin_out
        |-> !bios_32k && rom_addr[15]) else $error("address 15 driven wrongly");
    rom_addr_a: assert property (boot_rom_select_n_oe && !boot_rom_select_n_out
        |-> rom_addr_upper_pins_oe && rom_addr_upper_pins_out == rom_addr[14:7])
        else $error("rom address pins wrong");
    rom_absent_a: assert property (rom_absent
        |-> !(boot_rom_select_n_oe && !boot_rom_select_n_out)) else $error("absent rom selected");
    test_upper_a: assert property (mode_sel == `MODE_TEST |-> rom_addr_upper_pins_oe
        && rom_addr_upper_pins_out == test_out[31:24] && rom_data_pins_out == test_out[7:0])
        else $error("test outputs wrong");
    video_strobe_a: assert property (mode_sel == `MODE_VIDEO && !video_sub_mode
        |-> rom_addr_bit6_pin_out == !host_cycle && rom_addr_bit5_pin_out == !host_write
        && rom_addr_low_pins_out == host_addr_bus) else $error("video strobes wrong");
    strap_hold_a: assert property ($past(rst_b, 2) && $past(rst_b)
        |-> $stable({bios_32k, pixel_bus_en, rom_absent})) else $error("straps changed");

    cover property (boot_rom_select_n_oe && !boot_rom_select_n_out);
    cover property (mode_sel == `MODE_TEST);
    cover property (mode_sel == `MODE_VIDEO && video_sub_mode);
endmodule

bind rom_video_port_pin_mux pin_mux_asserts pin_mux_asserts_i (.*);

// [testbench/tb.sv]
// self-checking bench for the rom / video-module pin multiplexer
// assumes the design and its defines header are on the include path
`timescale 1ns/10ps
`include "pin_mux_defines.vh"

module tb;
    logic ref_clk = 1'h0, rst_b, video_sub_mode, vsync_polarity, rom_read_req, host_write;
    logic host_cycle, periph_select, vsync_core, gpio_out, gpio_oe, serial2_clock_drive_low;
    logic serial2_data_drive_low, strap_32k, strap_absent, strap_nopix, ack_pin, sync_pin;
    logic video_buffer_enable_n_in, rom_rdata_valid_r, transfer_ack_r, video_valid_r, gpio_in_r;
    logic serial2_clock_r, serial2_data_r, bios_32k, pixel_bus_en, rom_absent, vsync_pin_in;
    logic vsync_pin_out, vsync_pin_oe, rom_addr_bit15_pin_in, rom_addr_bit15_pin_out;
    logic rom_addr_bit15_pin_oe, rom_addr_upper_pins_oe, rom_addr_bit6_pin_in;
    logic rom_addr_bit6_pin_out, rom_addr_bit6_pin_oe, rom_addr_bit5_pin_in, rom_addr_bit5_pin_out;
    logic rom_addr_bit5_pin_oe, rom_addr_bit4_pin_in, rom_addr_bit4_pin_out, rom_addr_bit4_pin_oe;
    logic rom_addr_low_pins_oe, periph_select_n_in, periph_select_n_out, periph_select_n_oe;
    logic rom_data_pins_oe, boot_rom_select_n_in, boot_rom_select_n_out, boot_rom_select_n_oe;
    logic serial2_clock_in, serial2_clock_out, serial2_clock_oe, sync_buffer_enable_n_in;
    logic sync_buffer_enable_n_out, sync_buffer_enable_n_oe;
    logic [1:0]  mode_sel;
    logic [3:0]  host_addr_bus, rom_addr_low_pins_in, rom_addr_low_pins_out;
    logic [7:0]  host_wdata, pixel_data, vid_pins, rom_rdata_r, host_rdata_r, video_in_bus_r;
    logic [7:0]  rom_data_pins_in, rom_data_pins_out, rom_addr_upper_pins_in, rom_addr_upper_pins_out;
    logic [15:0] rom_addr;
    logic [31:0] test_out;
    int          checked = 0, miscompares = 0;

    // ******
    // pins resolved with their pull-ups
    // ******
    assign rom_addr_upper_pins_in = rom_addr_upper_pins_oe ? rom_addr_upper_pins_out : vid_pins;
    assign rom_addr_low_pins_in = rom_addr_low_pins_oe ? rom_addr_low_pins_out : {2'h3, !strap_nopix, 1'h1};
    assign rom_addr_bit4_pin_in = rom_addr_bit4_pin_oe ? rom_addr_bit4_pin_out : ack_pin;
    assign rom_addr_bit6_pin_in = rom_addr_bit6_pin_oe ? rom_addr_bit6_pin_out : 1'h1;
    assign rom_addr_bit5_pin_in = rom_addr_bit5_pin_oe ? rom_addr_bit5_pin_out : 1'h1;
    assign periph_select_n_in = periph_select_n_oe ? periph_select_n_out : 1'h1;
    assign vsync_pin_in = vsync_pin_oe ? vsync_pin_out : 1'h1;
    assign serial2_clock_in = !(serial2_clock_oe && !serial2_clock_out);
    assign sync_buffer_enable_n_in = sync_buffer_enable_n_oe ? sync_buffer_enable_n_out : sync_pin;

    rom_video_port_pin_mux rom_video_port_pin_mux_i (.*);
    boot_rom_model boot_rom_model_i (.*);

    initial
        forever #12.5 ref_clk = ~ref_clk;

    // ******
    // helpers
    // ******
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic s32, input logic sabs, input logic snopix);
        cyc(1);
        rst_b = 1'h0;
        {strap_32k, strap_absent, strap_nopix} = {s32, sabs, snopix};
        cyc(6);
        rst_b = 1'h1;
        cyc(3);
        chk("bios_32k", s32, bios_32k);
        chk("rom_absent", sabs, rom_absent);
        chk("pixel_bus_en", !snopix, pixel_bus_en);
    endtask

    // ******
    // scenarios
    // ******
    task automatic t_rom();
        for (int i = 0; i < 2; i++)
        begin
            rom_addr = i ? 16'h8A80 : 16'h7F00;
            rom_read_req = 1'h1;
            strap_32k = 1'h1;
            cyc(5);
            chk("rom_sel", 1'h0, boot_rom_select_n_out);
            chk("rom_data", rom_addr[14:7] ^ 8'hA5, rom_rdata_r);
            chk("rom_valid", 1'h1, rom_rdata_valid_r);
            chk("bit15", {1'h1, rom_addr[15]}, {rom_addr_bit15_pin_oe, rom_addr_bit15_pin_out});
            chk("bios_hold", 1'h0, bios_32k);
            rom_read_req = 1'h0;
            strap_32k = 1'h0;
            cyc(1);
        end
    endtask

    task automatic t_absent();
        rom_read_req = 1'h1;
        cyc(5);
        chk("absent_sel", 1'h0, boot_rom_select_n_oe && !boot_rom_select_n_out);
        chk("absent_valid", 1'h0, rom_rdata_valid_r);
        rom_read_req = 1'h0;
    endtask

    task automatic t_pixel(input logic en);
        pixel_data = 8'h3C;
        video_buffer_enable_n_in = 1'h0;
        cyc(4);
        chk("pix_oe", en, rom_addr_upper_pins_oe);
        if (en)
            chk("pix", 8'h3C, rom_addr_upper_pins_out);
        video_buffer_enable_n_in = 1'h1;
        cyc(4);
        chk("pix_off", 1'h0, rom_addr_upper_pins_oe);
    endtask

    task automatic t_vsync();
        sync_pin = 1'h1;
        vsync_core = 1'h1;
        for (int p = 0; p < 2; p++)
        begin
            vsync_polarity = p[0];
            cyc(4);
            chk("vsync", {1'h1, !p[0]}, {vsync_pin_oe, vsync_pin_out});
        end
        sync_pin = 1'h0;
        cyc(4);
        chk("vsync_float", 1'h0, vsync_pin_oe);
        mode_sel = `MODE_VIDEO;
        gpio_oe = 1'h1;
        cyc(4);
        chk("gpio_pin", 2'h2, {sync_buffer_enable_n_oe, sync_buffer_enable_n_out});
        chk("gpio_in0", 1'h0, gpio_in_r);
        gpio_oe = 1'h0;
        sync_pin = 1'h1;
        cyc(4);
        chk("gpio_in1", 1'h1, gpio_in_r);
    endtask

    task automatic t_video();
        mode_sel = `MODE_VIDEO;
        for (int s = 0; s < 2; s++)
        begin
            video_sub_mode = s[0];
            for (int k = 0; k < 4; k++)
            begin
                {host_cycle, host_write} = k[1:0];
                {periph_select, host_addr_bus, host_wdata} = {k[0], 4'h5 + k[3:0], 8'h96};
                cyc(1);
                chk("strobes", s ? {!(k[1] && !k[0]), !(k[1] && k[0])} : {!k[1], !k[0]},
                    {rom_addr_bit6_pin_out, rom_addr_bit5_pin_out});
                chk("host_addr", {!k[0], 4'h5 + k[3:0]}, {periph_select_n_out,
                    rom_addr_low_pins_out});
                chk("host_data", k == 3 ? 9'h196 : 9'h000, {rom_data_pins_oe,
                    rom_data_pins_out & {8{rom_data_pins_oe}}});
            end
            for (int a = 1; a >= 0; a--)
            begin
                ack_pin = s[0] ~^ a[0];
                cyc(4);
                chk("ack", a[0], transfer_ack_r);
                chk("host_rdata", 8'h96, host_rdata_r);
            end
        end
        vid_pins = 8'h69;
        cyc(4);
        chk("video", 10'h369, {!rom_addr_upper_pins_oe, video_valid_r, video_in_bus_r});
    endtask

    task automatic t_test();
        mode_sel = `MODE_TEST;
        for (int i = 0; i < 2; i++)
        begin
            test_out = i ? 32'h5A3C_A5C3 : 32'hA5C3_5A3C;
            cyc(1);
            chk("test_pins", {test_out[31:24], test_out[15:0]}, {rom_addr_upper_pins_out,
                periph_select_n_out, rom_addr_low_pins_out, rom_addr_bit4_pin_out,
                rom_addr_bit5_pin_out, rom_addr_bit6_pin_out, rom_data_pins_out});
            chk("test_oe", 7'h7F, {rom_addr_upper_pins_oe, periph_select_n_oe, rom_addr_low_pins_oe,
                rom_addr_bit4_pin_oe, rom_addr_bit5_pin_oe, rom_addr_bit6_pin_oe,
                rom_data_pins_oe});
        end
        mode_sel = `MODE_ROM;
    endtask

    task automatic t_serial();
        rom_addr = 16'hFFFF;
        rom_read_req = 1'h1;
        cyc(4);
        chk("bit15_32k", 1'h0, rom_addr_bit15_pin_oe);
        rom_read_req = 1'h0;
        {serial2_clock_drive_low, serial2_data_drive_low} = 2'h3;
        cyc(4);
        chk("serial_pins", 4'hA, {rom_addr_bit15_pin_oe, rom_addr_bit15_pin_out,
            serial2_clock_oe, serial2_clock_out});
        chk("serial_low", 2'h0, {serial2_clock_r, serial2_data_r});
        {serial2_clock_drive_low, serial2_data_drive_low} = 2'h0;
        cyc(4);
        chk("serial_high", 2'h3, {serial2_clock_r, serial2_data_r});
    endtask

    initial
    begin
        {video_sub_mode, vsync_polarity, rom_read_req, host_write, host_cycle, periph_select} = '0;
        {vsync_core, gpio_out, gpio_oe, serial2_clock_drive_low, serial2_data_drive_low} = '0;
        {mode_sel, host_addr_bus, host_wdata, pixel_data, vid_pins, rom_addr, test_out} = '0;
        {rst_b, ack_pin, sync_pin, video_buffer_enable_n_in} = 4'h1;
        {strap_32k, strap_absent, strap_nopix} = 3'h0;
        do_reset(1'h0, 1'h0, 1'h0);
        t_rom();
        t_pixel(1'h1);
        t_vsync();
        t_video();
        t_test();
        do_reset(1'h1, 1'h0, 1'h1);
        t_serial();
        t_pixel(1'h0);
        do_reset(1'h0, 1'h1, 1'h0);
        t_absent();
        wrap_up();
    end

    // run takes under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
endmodule
